// [common/hadr_pkg.sv]
// shared constants and types for the host address decode router
package hadr_pkg;
  localparam int ADDR_W = 36;
  // apic configuration space
  localparam logic [35:0] APIC_BASE = 36'h0_fec0_0000;
  localparam logic [35:0] IOAPIC_TOP = 36'h0_fec7_ffff;
  localparam logic [35:0] XAPIC_BASE = 36'h0_fec8_0000;
  localparam logic [35:0] APIC_TOP = 36'h0_fecf_ffff;
  // high smm segment and its dram target
  localparam logic [35:0] HIGH_SMM_SEGMENT_BASE = 36'h0_feda_0000;
  localparam logic [35:0] HIGH_SMM_SEGMENT_TOP = 36'h0_fedb_ffff;
  localparam logic [35:0] LEGACY_SMM_BASE = 36'h0_000a_0000;
  // interrupt message space and high bios
  localparam logic [35:0] INTR_BASE = 36'h0_fee0_0000;
  localparam logic [35:0] INTR_TOP = 36'h0_feef_ffff;
  localparam logic [35:0] HIBIOS_BASE = 36'h0_ffe0_0000;
  localparam logic [35:0] FOUR_GB = 36'h1_0000_0000;
  // apb register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TOLD = 12'h004;
  localparam logic [11:0] REG_TOUD = 12'h008;
  localparam logic [11:0] REG_TOPM = 12'h00c;
  localparam logic [11:0] REG_RMB = 12'h010;
  localparam logic [11:0] REG_RML = 12'h014;
  localparam logic [11:0] REG_MWIN = 12'h018;
  localparam logic [11:0] REG_PWIN = 12'h01c;
  localparam logic [11:0] REG_PWBU = 12'h020;
  localparam logic [11:0] REG_PWLU = 12'h024;
  localparam logic [11:0] REG_STAT = 12'h028;
  // control register bit positions
  localparam int CTRL_XAPIC = 0;
  localparam int CTRL_HIGH_SMM_SEGMENT = 1;
  localparam int CTRL_RECLAIM = 2;
  localparam int CTRL_MEM_EN = 3;
  // reset values
  localparam logic [11:0] TOLD_RST = 12'h001;
  localparam logic [31:0] WIN_RST = 32'h0000_fff0;
  // request sources
  typedef enum logic [1:0] {
    HADR_SRC_HOST = 2'b00,
    HADR_SRC_HUB = 2'b01,
    HADR_SRC_PORT = 2'b10
  } hadr_src_t;
  // routing targets
  typedef enum logic [2:0] {
    HADR_DST_DRAM = 3'd0,
    HADR_DST_HUB = 3'd1,
    HADR_DST_PORT = 3'd2,
    HADR_DST_HOSTBUS = 3'd3,
    HADR_DST_INVALID = 3'd4
  } hadr_dst_t;
endpackage

// [logic/hadr_window.sv]
`timescale 1ns/100ps
// inclusive window compare with 1 mb granularity
module hadr_window (
  // address under test
  input wire logic [35:0] addr,
  // window bounds in 1 mb units, bits 35:20
  input wire logic [15:0] base_mb,
  input wire logic [15:0] limit_mb,
  // result
  output logic hit
);
  import hadr_pkg::*;
  // low base bits zero, low limit bits ones, so a compare on 35:20 is exact
  assign hit = (addr[35:20] >= base_mb) && (addr[35:20] <= limit_mb);
endmodule

// [logic/hadr_router.sv]
`timescale 1ns/100ps
// address decode and routing above top of low dram, with apb registers
// How it works
// - ioapic default region goes to hub link
// - extra apic range to port when enabled
// - whole apic range to hub when disabled
// - smm high segment remapped to legacy smm
// - non-smm high segment access terminated invalid
// - non-smm writebacks remapped into smm space
// - port or hub cycles to smm refused
// - dram behind high segment never reachable
// - writebacks to high segment complete to dram
// - inbound interrupt writes forwarded to host bus
// - interrupt transaction ends with target ready
// - top 2 mb bios goes to hub
// - upstream above 36 bits is invalid
// - reclaim window redirects to top of low dram
// - top of upper dram equals reclaim limit
// - window bounds give bits 31:20, 1 mb grain
// - inclusive window hit claims for port
// - windows decode only with memory enable
// - upper prefetch bounds reach above 4 gb
// - top of memory reports populated size
// - unmatched hole addresses default to hub
module hadr_router (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // incoming request
  input wire logic req_valid,
  input wire hadr_pkg::hadr_src_t req_src,
  input wire logic [36:0] req_addr,
  input wire logic req_write,
  input wire logic req_smm,
  input wire logic req_wb,
  input wire logic [31:0] req_data,
  // routed answer, one cycle after the request
  output logic rt_valid,
  output hadr_pkg::hadr_dst_t rt_dst,
  output logic [35:0] rt_addr,
  output logic rt_intr_msg,
  output logic [31:0] rt_data,
  output logic host_target_ready_n
);
  import hadr_pkg::*;

  // software visible configuration
  logic [3:0] ctrl_r;
  logic [11:0] top_of_low_dram_r;
  logic [15:0] top_of_upper_dram_r;
  logic [15:0] top_of_populated_memory_r;
  logic [15:0] remap_window_base_r;
  logic [15:0] remap_window_limit_r;
  logic [31:0] mem_window_r;
  logic [31:0] pref_window_r;
  logic [3:0] port_pref_window_base_upper_r;
  logic [3:0] port_pref_window_limit_upper_r;
  logic [7:0] route_count_r;
  logic [2:0] last_dst_r;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // slave answers in the first access cycle, so no wait states
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == REG_CTRL) begin
      rd_mux = {28'h0000_000, ctrl_r};
    end else if (paddr == REG_TOLD) begin
      rd_mux = {top_of_low_dram_r, 20'h00000};
    end else if (paddr == REG_TOUD) begin
      rd_mux = {16'h0000, top_of_upper_dram_r};
    end else if (paddr == REG_TOPM) begin
      rd_mux = {16'h0000, top_of_populated_memory_r};
    end else if (paddr == REG_RMB) begin
      rd_mux = {16'h0000, remap_window_base_r};
    end else if (paddr == REG_RML) begin
      rd_mux = {16'h0000, remap_window_limit_r};
    end else if (paddr == REG_MWIN) begin
      rd_mux = mem_window_r;
    end else if (paddr == REG_PWIN) begin
      rd_mux = pref_window_r;
    end else if (paddr == REG_PWBU) begin
      rd_mux = {28'h0000_000, port_pref_window_base_upper_r};
    end else if (paddr == REG_PWLU) begin
      rd_mux = {28'h0000_000, port_pref_window_limit_upper_r};
    end else if (paddr == REG_STAT) begin
      rd_mux = {21'h00_0000, last_dst_r, route_count_r};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // apb handshake and read data, error for unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= rd_mux;
      end
    end
  end

  // register writes take effect on the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 4'h0;
      top_of_low_dram_r <= TOLD_RST;
      top_of_upper_dram_r <= 16'h0000;
      top_of_populated_memory_r <= 16'h0000;
      remap_window_base_r <= 16'hffff;
      remap_window_limit_r <= 16'h0000;
      mem_window_r <= WIN_RST;
      pref_window_r <= WIN_RST;
      port_pref_window_base_upper_r <= 4'h0;
      port_pref_window_limit_upper_r <= 4'h0;
    end else if (wr_en && pready) begin
      if (paddr == REG_CTRL) begin
        ctrl_r <= pwdata[3:0];
        // turning reclaim on must not leave the upper bound stale
        if (pwdata[CTRL_RECLAIM]) begin
          top_of_upper_dram_r <= remap_window_limit_r;
        end
      end else if (paddr == REG_TOLD) begin
        top_of_low_dram_r <= pwdata[31:20];
      end else if (paddr == REG_TOUD) begin
        top_of_upper_dram_r <= pwdata[15:0];
      end else if (paddr == REG_TOPM) begin
        top_of_populated_memory_r <= pwdata[15:0];
      end else if (paddr == REG_RMB) begin
        remap_window_base_r <= pwdata[15:0];
      end else if (paddr == REG_RML) begin
        remap_window_limit_r <= pwdata[15:0];
        if (ctrl_r[CTRL_RECLAIM]) begin
          top_of_upper_dram_r <= pwdata[15:0];
        end
      end else if (paddr == REG_MWIN) begin
        mem_window_r <= {pwdata[31:20], 4'h0, pwdata[15:4], 4'h0};
      end else if (paddr == REG_PWIN) begin
        pref_window_r <= {pwdata[31:20], 4'h0, pwdata[15:4], 4'h0};
      end else if (paddr == REG_PWBU) begin
        port_pref_window_base_upper_r <= pwdata[3:0];
      end else if (paddr == REG_PWLU) begin
        port_pref_window_limit_upper_r <= pwdata[3:0];
      end
    end
  end

  // window bounds in 1 mb units
  logic [15:0] mw_base;
  logic [15:0] mw_limit;
  logic [15:0] pw_base;
  logic [15:0] pw_limit;
  logic mw_hit;
  logic pw_hit;
  logic [35:0] a;

  assign a = req_addr[35:0];
  assign mw_base = {4'h0, mem_window_r[15:4]};
  assign mw_limit = {4'h0, mem_window_r[31:20]};
  assign pw_base = {port_pref_window_base_upper_r, pref_window_r[15:4]};
  assign pw_limit = {port_pref_window_limit_upper_r, pref_window_r[31:20]};

  hadr_window u_mem_win (
    .addr(a),
    .base_mb(mw_base),
    .limit_mb(mw_limit),
    .hit(mw_hit)
  );

  hadr_window u_pref_win (
    .addr(a),
    .base_mb(pw_base),
    .limit_mb(pw_limit),
    .hit(pw_hit)
  );

  // inclusive range test on a 36 bit address
  function automatic logic in_rng(input logic [35:0] x, input logic [35:0] lo, input logic [35:0] hi);
    in_rng = (x >= lo) && (x <= hi);
  endfunction

  // route decision
  hadr_dst_t dst_nxt;
  logic [35:0] addr_nxt;
  logic intr_nxt;
  logic from_host;
  logic high_smm_segment_en;
  logic port_mem_en;
  logic in_low;
  logic in_high_smm_segment;
  logic in_reclaim;

  assign from_host = (req_src == HADR_SRC_HOST);
  assign high_smm_segment_en = ctrl_r[CTRL_HIGH_SMM_SEGMENT];
  assign port_mem_en = ctrl_r[CTRL_MEM_EN];
  assign in_low = (a < {4'h0, top_of_low_dram_r, 20'h00000});
  assign in_high_smm_segment = in_rng(a, HIGH_SMM_SEGMENT_BASE, HIGH_SMM_SEGMENT_TOP);
  assign in_reclaim = ctrl_r[CTRL_RECLAIM] && (a[35:20] >= remap_window_base_r)
                      && (a[35:20] <= remap_window_limit_r);

  // positive decodes first, subtractive hub default last
  always_comb begin
    dst_nxt = HADR_DST_HUB;
    addr_nxt = a;
    intr_nxt = 1'b0;
    if (!from_host && req_addr[36]) begin
      dst_nxt = HADR_DST_INVALID;
    end else if (in_reclaim) begin
      dst_nxt = HADR_DST_DRAM;
      addr_nxt = a - {remap_window_base_r, 20'h00000} + {4'h0, top_of_low_dram_r, 20'h00000};
    end else if (a >= FOUR_GB) begin
      if (port_mem_en && pw_hit) begin
        dst_nxt = HADR_DST_PORT;
      end else if (a[35:20] < top_of_upper_dram_r) begin
        dst_nxt = HADR_DST_DRAM;
      end
    end else if (in_low) begin
      dst_nxt = HADR_DST_DRAM;
    end else if (high_smm_segment_en && in_high_smm_segment) begin
      // the dram at the segment address itself is never used
      if (!from_host) begin
        dst_nxt = HADR_DST_INVALID;
      end else if (req_smm || req_wb) begin
        dst_nxt = HADR_DST_DRAM;
        addr_nxt = LEGACY_SMM_BASE + {20'h00000, a[15:0]} + {19'h00000, a[16], 16'h0000};
      end else begin
        dst_nxt = HADR_DST_INVALID;
      end
    end else if (!from_host && req_write && in_rng(a, INTR_BASE, INTR_TOP)) begin
      dst_nxt = HADR_DST_HOSTBUS;
      intr_nxt = 1'b1;
    end else if (in_rng(a, XAPIC_BASE, APIC_TOP) && ctrl_r[CTRL_XAPIC]) begin
      dst_nxt = HADR_DST_PORT;
    end else if (in_rng(a, APIC_BASE, APIC_TOP)) begin
      dst_nxt = HADR_DST_HUB;
    end else if (a >= HIBIOS_BASE) begin
      dst_nxt = HADR_DST_HUB;
    end else if (port_mem_en && (mw_hit || pw_hit)) begin
      dst_nxt = HADR_DST_PORT;
    end
  end

  // registered routing outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_valid <= 1'b0;
      rt_dst <= HADR_DST_HUB;
      rt_addr <= 36'h0_0000_0000;
      rt_intr_msg <= 1'b0;
      rt_data <= 32'h0000_0000;
      host_target_ready_n <= 1'b1;
    end else begin
      rt_valid <= req_valid;
      rt_dst <= dst_nxt;
      rt_addr <= addr_nxt;
      rt_intr_msg <= req_valid && intr_nxt;
      rt_data <= req_data; // interrupt data rides along with the message
      host_target_ready_n <= !(req_valid && intr_nxt);
    end
  end

  // status: count of routed requests and last target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_count_r <= 8'h00;
      last_dst_r <= 3'h1;
    end else if (req_valid) begin
      route_count_r <= route_count_r + 8'h01;
      last_dst_r <= dst_nxt;
    end
  end
endmodule

// [bench/hadr_router_monitor.sv]
// checker of routing results against the decode rules
`timescale 1ns/100ps
module hadr_router_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // request and result
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_smm,
  input wire logic req_wb,
  input wire hadr_pkg::hadr_src_t req_src,
  input wire logic [36:0] req_addr,
  input wire logic rt_valid,
  input wire logic rt_intr_msg,
  input wire logic host_target_ready_n,
  input wire hadr_pkg::hadr_dst_t rt_dst,
  input wire logic [35:0] rt_addr
);
  import hadr_pkg::*;
  logic [3:0] ctrl_r;
  logic [35:0] addr_r;
  logic host, up, hs;
  // shadow of the control bits, moved at the edge where the write lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == REG_CTRL) ctrl_r <= pwdata[3:0];
  end
  // request address kept for the remap check one cycle later
  always_ff @(posedge pclk) addr_r <= req_addr[35:0];
  assign host = req_valid && req_src == HADR_SRC_HOST && !req_addr[36];
  assign up = req_valid && req_src != HADR_SRC_HOST && !req_addr[36];
  assign hs = req_addr[35:0] inside {[HIGH_SMM_SEGMENT_BASE:HIGH_SMM_SEGMENT_TOP]} && ctrl_r[CTRL_HIGH_SMM_SEGMENT];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IOAPIC: assert property (host && req_addr[35:0] inside {[APIC_BASE:IOAPIC_TOP]}
    |=> rt_valid && rt_dst == HADR_DST_HUB) else $error("ioapic access not on hub");
  AST_XAPIC_ON: assert property (host && req_addr[35:0] inside {[XAPIC_BASE:APIC_TOP]} && ctrl_r[CTRL_XAPIC]
    |=> rt_dst == HADR_DST_PORT) else $error("extra apic access not on port");
  AST_XAPIC_OFF: assert property (host && req_addr[35:0] inside {[XAPIC_BASE:APIC_TOP]} && !ctrl_r[CTRL_XAPIC]
    |=> rt_dst == HADR_DST_HUB) else $error("apic access not on hub");
  AST_HIGH_SMM_SEGMENT_SMM: assert property (host && hs && (req_smm || req_wb) |=> rt_dst == HADR_DST_DRAM
    && rt_addr == LEGACY_SMM_BASE + addr_r - HIGH_SMM_SEGMENT_BASE) else $error("high segment remap wrong");
  AST_HIGH_SMM_SEGMENT_PLAIN: assert property (host && hs && !req_smm && !req_wb
    |=> rt_dst == HADR_DST_INVALID) else $error("plain high segment access not invalid");
  AST_HIGH_SMM_SEGMENT_UP: assert property (up && hs |=> rt_dst == HADR_DST_INVALID) else $error("upstream smm access let in");
  AST_INTR: assert property (up && req_write && req_addr[35:0] inside {[INTR_BASE:INTR_TOP]}
    |=> rt_intr_msg && rt_dst == HADR_DST_HOSTBUS) else $error("interrupt write not forwarded");
  // back to back messages keep target ready low, so the check is per cycle
  AST_TRDY: assert property (rt_intr_msg || !host_target_ready_n
    |-> rt_valid && rt_intr_msg && !host_target_ready_n && rt_dst == HADR_DST_HOSTBUS)
    else $error("target ready not paired with message");
  AST_BIOS: assert property (host && req_addr[35:0] >= HIBIOS_BASE && req_addr[35:0] < FOUR_GB
    |=> rt_dst == HADR_DST_HUB) else $error("high bios not on hub");
  AST_WIDE: assert property (req_valid && req_src != HADR_SRC_HOST && req_addr[36]
    |=> rt_dst == HADR_DST_INVALID) else $error("wide upstream address not invalid");
endmodule
bind hadr_router hadr_router_monitor hadr_router_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .req_valid(req_valid),
  .req_write(req_write), .req_smm(req_smm), .req_wb(req_wb), .req_src(req_src), .req_addr(req_addr),
  .rt_valid(rt_valid), .rt_intr_msg(rt_intr_msg), .host_target_ready_n(host_target_ready_n), .rt_dst(rt_dst),
  .rt_addr(rt_addr));

// [bench/hadr_far_end.sv]
// host bus end that takes interrupt message transactions
`timescale 1ns/100ps
module hadr_far_end (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // routed side
  input wire logic rt_intr_msg,
  input wire logic host_target_ready_n,
  // messages taken
  output logic [7:0] n_intr
);
  // a message counts only when target ready closes it in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) n_intr <= 8'h00;
    else if (rt_intr_msg && !host_target_ready_n) n_intr <= n_intr + 8'h01;
  end
endmodule

// [bench/testbench.sv]
// self-checking bench for the host address decode router
`timescale 1ns/100ps
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, x); end end
module testbench;
  import hadr_pkg::*;
  typedef struct {hadr_dst_t d; logic [35:0] a; logic i; logic [31:0] x;} hadr_note_t;
  localparam hadr_src_t H = HADR_SRC_HOST, U = HADR_SRC_HUB, P = HADR_SRC_PORT;
  localparam hadr_dst_t DR = HADR_DST_DRAM, HB = HADR_DST_HUB, PT = HADR_DST_PORT;
  localparam hadr_dst_t HS = HADR_DST_HOSTBUS, IV = HADR_DST_INVALID;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_smm = 1'b0, req_wb = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, req_data = 32'h0, seed = 32'h1cb28b04, prdata, rt_data, r;
  logic [36:0] req_addr = 37'h0;
  logic [35:0] rt_addr, o;
  logic pready, pslverr, rt_valid, rt_intr_msg, host_target_ready_n, e;
  logic [7:0] n_intr;
  hadr_src_t req_src = HADR_SRC_HOST;
  hadr_dst_t rt_dst;
  hadr_note_t q[$];
  hadr_note_t m;
  int mismatches = 0, n_compared = 0;
  always #2.5 pclk = ~pclk;
  hadr_router hadr_router_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_src(req_src), .req_addr(req_addr), .req_write(req_write), .req_smm(req_smm), .req_wb(req_wb),
    .req_data(req_data), .rt_valid(rt_valid), .rt_dst(rt_dst), .rt_addr(rt_addr), .rt_intr_msg(rt_intr_msg),
    .rt_data(rt_data), .host_target_ready_n(host_target_ready_n));
  hadr_far_end hadr_far_end_i (.pclk(pclk), .presetn(presetn), .rt_intr_msg(rt_intr_msg),
    .host_target_ready_n(host_target_ready_n), .n_intr(n_intr));
  // lfsr step, also feeds the request data
  function automatic logic [35:0] rn(input logic [31:0] k);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {4'h0, seed & k};
  endfunction
  task close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // apb transfer; also ends any request stream so no request repeats
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req_valid <= 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one request per edge; the expected route goes on the queue
  task rq(input hadr_src_t s, input logic [36:0] a, input hadr_dst_t d, input logic [35:0] ea = '1,
    input logic w = 1'b0, input logic sm = 1'b0, input logic wb = 1'b0);
    hadr_note_t n;
    n.x = 32'(rn(32'hffff_ffff));
    n.d = d;
    n.a = (ea === '1) ? a[35:0] : ea;
    n.i = (d == HADR_DST_HOSTBUS);
    q.push_back(n);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_src <= s;
    req_addr <= a;
    req_write <= w;
    req_smm <= sm;
    req_wb <= wb;
    req_data <= n.x;
  endtask
  // results are looked at mid-cycle, where registered outputs have settled
  always @(negedge pclk) begin
    if (rt_valid === 1'b1) begin
      if (q.size() == 0) `CHK(rt_valid, 1'b0)
      else begin
        m = q.pop_front();
        `CHK(rt_dst, m.d)
        if (m.d != HADR_DST_INVALID) `CHK(rt_addr, m.a)
        `CHK(rt_intr_msg, m.i)
        `CHK(host_target_ready_n, !m.i)
        `CHK(rt_data, m.x)
      end
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(REG_TOLD, 1'b1, 32'h4000_0000);
    apb(REG_TOLD, 1'b0, 32'h0);
    `CHK(r, 32'h4000_0000)
    `CHK(e, 1'b0)
    apb(REG_MWIN, 1'b1, 32'h80f0_8000);
    // unmapped offset: error flagged, read data zero
    apb(12'h030, 1'b0, 32'h0);
    `CHK(r, 32'h0)
    `CHK(e, 1'b1)
    rq(H, APIC_BASE + rn(32'h7_ffff), HB);
    rq(H, XAPIC_BASE + rn(32'h7_ffff), HB);
    rq(H, HIGH_SMM_SEGMENT_BASE + rn(32'h1_ffff), HB);
    rq(H, HIBIOS_BASE + rn(32'h1f_ffff), HB);
    rq(U, INTR_BASE + rn(32'hf_ffff), HS, '1, 1'b1);
    rq(P, INTR_TOP, HS, '1, 1'b1);
    rq(U, INTR_BASE, HB);
    rq(P, {1'b1, rn(32'hffff_ffff)}, IV);
    rq(H, 37'h0_8000_0000, HB);
    apb(REG_CTRL, 1'b1, 32'h0000_000b);
    rq(H, 37'h0_8000_0000, PT);
    rq(H, 37'h0_80ff_ffff, PT);
    rq(H, 37'h0_8100_0000, HB);
    rq(H, XAPIC_BASE + rn(32'h7_ffff), PT);
    rq(H, IOAPIC_TOP, HB);
    o = rn(32'h1_ffff);
    rq(H, HIGH_SMM_SEGMENT_BASE + o, DR, LEGACY_SMM_BASE + o, 1'b0, 1'b1);
    rq(H, HIGH_SMM_SEGMENT_BASE + o, IV);
    rq(H, HIGH_SMM_SEGMENT_BASE + o, DR, LEGACY_SMM_BASE + o, 1'b1, 1'b0, 1'b1);
    rq(U, HIGH_SMM_SEGMENT_BASE + o, IV, '1, 1'b1);
    apb(REG_RMB, 1'b1, 32'h0000_1000);
    apb(REG_RML, 1'b1, 32'h0000_13ff);
    apb(REG_PWIN, 1'b1, 32'h00f0_0000);
    apb(REG_PWBU, 1'b1, 32'h0000_0002);
    apb(REG_PWLU, 1'b1, 32'h0000_0002);
    apb(REG_CTRL, 1'b1, 32'h0000_000f);
    // limit was written with reclaim off; enabling reclaim must still align the upper bound
    apb(REG_TOUD, 1'b0, 32'h0);
    `CHK(r, 32'h0000_13ff)
    o = rn(32'hfff_ffff);
    rq(H, FOUR_GB + o, DR, 36'h0_4000_0000 + o);
    rq(H, 37'h1_5000_0000, HB);
    rq(H, 37'h2_0000_0000 + rn(32'hff_ffff), PT);
    apb(REG_TOPM, 1'b1, 32'h0000_1400);
    apb(REG_TOPM, 1'b0, 32'h0);
    `CHK(r, 32'h0000_1400)
    `CHK(q.size(), 0)
    `CHK(n_intr, 8'h02)
    // second reset in mid-run: enables and bounds must come back to their reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rq(H, 37'h0_8000_0000, HB);
    apb(REG_TOLD, 1'b0, 32'h0);
    `CHK(r[31:20], TOLD_RST)
    `CHK(n_intr, 8'h00)
    `CHK(q.size(), 0)
    close_out();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    close_out();
  end
endmodule
